// *** design/multi_port_parallel_io.sv ***
// Purpose: output latches, driver control and pin read paths of ports 0 to 4
// Assumes: pins are asynchronous and pass two flip-flops before use
// Notes: reads answer one cycle after the read strobe
// Notes on behaviour
// (R1) reset sets port 0 latches to one, driver selects to zero
// (R2) port 0 driver select: zero open drain, one push-pull
// (R3) software sets port 0 latch to one before clearing driver select for inputs
// (R4) software keeps port 0 latch one while pin is input or function
// (R5) ports 0,2,3,4 read latch and live pins at separate addresses
// (R6) port 1 direction bit: zero input, one output driven by latch
// (R7) reset clears port 1 directions and latches
// (R8) software sets port 1 latch then direction before timer output
// (R9) port 1 read returns latch for output-mode bits
// (R10) port 1 read returns pins for input bits; read-modify-write copies them
// (R11) port 2 has three bits; upper read bits undefined
// (R12) reset sets port 2 latches to one
// (R13) dual-clock mode gives port 2 bits 1,2 to the crystal
// (R14) falling edge of port 2 bit 0 output sets external interrupt latch
// (R15) stop mode floats port 2 bit 0 as stop release input
// (R16) reset sets port 3 latches to one
// (R17) reset sets port 4 latches to one, driver selects to zero
// (R18) port 4 driver select: zero open drain, one push-pull
// (R19) software sets port 4 latch to one before clearing driver select
// (R20) open-drain pin is released while its latch is one
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module multi_port_parallel_io (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [gpio_ports_pkg::ADDR_W-1:0] i_addr,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [gpio_ports_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_global_output_enable,
  input wire logic i_dual_clock_mode,
  input wire logic i_stop_mode,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] i_port0_pin,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] i_port1_pin,
  input wire logic [gpio_ports_pkg::P2_W-1:0] i_port2_pin,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] i_port3_pin,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] i_port4_pin,
  output logic [gpio_ports_pkg::DATA_W-1:0] o_port0_out,
  output logic [gpio_ports_pkg::DATA_W-1:0] o_port0_oe,
  output logic [gpio_ports_pkg::DATA_W-1:0] o_port1_out,
  output logic [gpio_ports_pkg::DATA_W-1:0] o_port1_oe,
  output logic [gpio_ports_pkg::P2_W-1:0] o_port2_out,
  output logic [gpio_ports_pkg::P2_W-1:0] o_port2_oe,
  output logic [gpio_ports_pkg::DATA_W-1:0] o_port3_out,
  output logic [gpio_ports_pkg::DATA_W-1:0] o_port3_oe,
  output logic [gpio_ports_pkg::DATA_W-1:0] o_port4_out,
  output logic [gpio_ports_pkg::DATA_W-1:0] o_port4_oe,
  output logic o_ext_int_edge,
  output logic o_stop_release,
  output logic o_crystal_select
);
  import gpio_ports_pkg::*;

  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_n;
  reg_req_type req;
  logic [DATA_W-1:0] port0_output_latch_q;
  logic [DATA_W-1:0] port0_driver_select_q;
  logic [DATA_W-1:0] port1_output_latch_q;
  logic [DATA_W-1:0] port1_direction_q;
  logic [P2_W-1:0] port2_output_latch_q;
  logic [DATA_W-1:0] port3_output_latch_q;
  logic [DATA_W-1:0] port4_output_latch_q;
  logic [DATA_W-1:0] port4_driver_select_q;
  logic [DATA_W-1:0] p0_meta_q;
  logic [DATA_W-1:0] port0_pin_state_q;
  logic [DATA_W-1:0] p1_meta_q;
  logic [DATA_W-1:0] p1_sync_q;
  logic [P2_W-1:0] p2_meta_q;
  logic [P2_W-1:0] port2_pin_state_q;
  logic [DATA_W-1:0] p3_meta_q;
  logic [DATA_W-1:0] port3_pin_state_q;
  logic [DATA_W-1:0] p4_meta_q;
  logic [DATA_W-1:0] port4_pin_state_q;
  logic p20_out_prev_q;
  logic ext_int_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] enable_all;
  logic [DATA_W-1:0] port1_read;
  logic p20_drive_d;
  port_drive_type p0_drive;
  port_drive_type p4_drive;
  logic p0_latch_we;
  logic p0_drv_we;
  logic p1_latch_we;
  logic p1_dir_we;
  logic p2_latch_we;
  logic p3_latch_we;
  logic p4_latch_we;
  logic p4_drv_we;
  logic [DATA_W-1:0] port2_latch_read;
  logic [DATA_W-1:0] port2_pin_read;

  // reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n = rst_sync2_q;

  assign req.wr = i_wr;
  assign req.rd = i_rd;
  assign req.addr = i_addr;
  assign req.wdata = i_wdata;

  // write decode, one enable per register
  assign p0_latch_we = req.wr && (req.addr == ADDR_P0_LATCH);
  assign p0_drv_we = req.wr && (req.addr == ADDR_P0_DRV);
  assign p1_latch_we = req.wr && (req.addr == ADDR_P1_LATCH);
  assign p1_dir_we = req.wr && (req.addr == ADDR_P1_DIR);
  assign p2_latch_we = req.wr && (req.addr == ADDR_P2_LATCH);
  assign p3_latch_we = req.wr && (req.addr == ADDR_P3_LATCH);
  assign p4_latch_we = req.wr && (req.addr == ADDR_P4_LATCH);
  assign p4_drv_we = req.wr && (req.addr == ADDR_P4_DRV);

  // pin synchronisers, one flip-flop pair per port
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_meta_q <= RST_ZERO;
      port0_pin_state_q <= RST_ZERO;
    end else begin
      p0_meta_q <= i_port0_pin;
      port0_pin_state_q <= p0_meta_q;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_meta_q <= RST_ZERO;
      p1_sync_q <= RST_ZERO;
    end else begin
      p1_meta_q <= i_port1_pin;
      p1_sync_q <= p1_meta_q;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      p2_meta_q <= '0;
      port2_pin_state_q <= '0;
    end else begin
      p2_meta_q <= i_port2_pin;
      port2_pin_state_q <= p2_meta_q;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      p3_meta_q <= RST_ZERO;
      port3_pin_state_q <= RST_ZERO;
    end else begin
      p3_meta_q <= i_port3_pin;
      port3_pin_state_q <= p3_meta_q;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      p4_meta_q <= RST_ZERO;
      port4_pin_state_q <= RST_ZERO;
    end else begin
      p4_meta_q <= i_port4_pin;
      port4_pin_state_q <= p4_meta_q;
    end
  end

  // port 0 output latch
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_output_latch_q <= RST_ONES; // R1
    end else if (p0_latch_we) begin
      port0_output_latch_q <= req.wdata;
    end
  end

  // port 0 driver select
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_driver_select_q <= RST_ZERO; // R1
    end else if (p0_drv_we) begin
      port0_driver_select_q <= req.wdata;
    end
  end

  // port 1 output latch
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_output_latch_q <= RST_ZERO; // R7
    end else if (p1_latch_we) begin
      port1_output_latch_q <= req.wdata;
    end
  end

  // port 1 direction
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_direction_q <= RST_ZERO; // R7
    end else if (p1_dir_we) begin
      port1_direction_q <= req.wdata;
    end
  end

  // port 2 output latch, three bits only
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      port2_output_latch_q <= RST_P2_ONES; // R12
    end else if (p2_latch_we) begin
      port2_output_latch_q <= req.wdata[P2_W-1:0]; // R11
    end
  end

  // port 3 output latch
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_output_latch_q <= RST_ONES; // R16
    end else if (p3_latch_we) begin
      port3_output_latch_q <= req.wdata;
    end
  end

  // port 4 output latch
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      port4_output_latch_q <= RST_ONES; // R17
    end else if (p4_latch_we) begin
      port4_output_latch_q <= req.wdata;
    end
  end

  // port 4 driver select
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      port4_driver_select_q <= RST_ZERO; // R17
    end else if (p4_drv_we) begin
      port4_driver_select_q <= req.wdata;
    end
  end

  // output drivers
  assign enable_all = {DATA_W{i_global_output_enable}};

  pin_driver #(.W(DATA_W)) u_port0_drv (
    .i_latch(port0_output_latch_q),
    .i_drv_sel(port0_driver_select_q),
    .i_enable(enable_all),
    .o_drive(p0_drive)
  ); // R2 R20
  pin_driver #(.W(DATA_W)) u_port4_drv (
    .i_latch(port4_output_latch_q),
    .i_drv_sel(port4_driver_select_q),
    .i_enable(enable_all),
    .o_drive(p4_drive)
  ); // R18 R20

  assign o_port0_out = p0_drive.out;
  assign o_port0_oe = p0_drive.oe;
  assign o_port4_out = p4_drive.out;
  assign o_port4_oe = p4_drive.oe;

  assign o_port1_out = port1_output_latch_q;
  assign o_port1_oe = port1_direction_q & enable_all; // R6

  // port 3 high-current sink port, released while latch is one
  assign o_port3_out = port3_output_latch_q;
  assign o_port3_oe = ~port3_output_latch_q & enable_all; // R20

  // port 2 open-drain style bits with secondary functions
  assign o_crystal_select = i_dual_clock_mode; // R13
  assign o_port2_out = port2_output_latch_q;
  assign o_port2_oe[P2_STOP_BIT] = p20_drive_d;
  assign o_port2_oe[P2_XIN_BIT] = ~i_dual_clock_mode & i_global_output_enable
    & ~port2_output_latch_q[P2_XIN_BIT]; // R13
  assign o_port2_oe[P2_XOUT_BIT] = ~i_dual_clock_mode & i_global_output_enable
    & ~port2_output_latch_q[P2_XOUT_BIT]; // R13
  assign p20_drive_d = ~i_stop_mode & i_global_output_enable
    & ~port2_output_latch_q[P2_STOP_BIT]; // R15
  assign o_stop_release = port2_pin_state_q[P2_STOP_BIT]; // R15

  // drive enable of bit 0, one cycle late
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      p20_out_prev_q <= 1'b0;
    end else begin
      p20_out_prev_q <= p20_drive_d;
    end
  end

  // falling edge of driven bit 0 raises the interrupt edge pulse
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_int_q <= 1'b0;
    end else begin
      ext_int_q <= p20_drive_d & ~p20_out_prev_q; // R14
    end
  end
  assign o_ext_int_edge = ext_int_q;

  // port 1 read mix: latch for outputs, pins for inputs
  assign port1_read = (port1_direction_q & port1_output_latch_q)
    | (~port1_direction_q & p1_sync_q); // R9 R10

  // port 2 reads, unused upper bits fixed
  assign port2_latch_read = {P2_UNUSED_READ[DATA_W-1:P2_W], port2_output_latch_q}; // R11
  assign port2_pin_read = {P2_UNUSED_READ[DATA_W-1:P2_W], port2_pin_state_q}; // R11

  // read mux
  always_comb begin
    rdata_d = RST_ZERO;
    case (req.addr)
      ADDR_P0_LATCH: rdata_d = port0_output_latch_q; // R5
      ADDR_P1_LATCH: rdata_d = port1_read;
      ADDR_P2_LATCH: rdata_d = port2_latch_read; // R5
      ADDR_P3_LATCH: rdata_d = port3_output_latch_q;
      ADDR_P4_LATCH: rdata_d = port4_output_latch_q;
      ADDR_P0_DRV: rdata_d = port0_driver_select_q;
      ADDR_P1_DIR: rdata_d = port1_direction_q;
      ADDR_P4_DRV: rdata_d = port4_driver_select_q;
      ADDR_P0_PIN: rdata_d = port0_pin_state_q; // R5
      ADDR_P2_PIN: rdata_d = port2_pin_read; // R5
      ADDR_P3_PIN: rdata_d = port3_pin_state_q; // R5
      ADDR_P4_PIN: rdata_d = port4_pin_state_q; // R5
      default: rdata_d = RST_ZERO;
    endcase
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RST_ZERO;
    end else if (req.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= RST_ZERO;
    end
  end
  assign o_rdata = rdata_q;
endmodule : multi_port_parallel_io

// *** design/gpio_ports_pkg.sv ***
// Purpose: constants and carriers for the five-port parallel i/o block
// Assumes: byte-wide register port, addresses as in the port map
// Notes: offsets are register addresses on the plain register port
package gpio_ports_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int P2_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_P0_LATCH = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_P1_LATCH = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_P2_LATCH = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_P3_LATCH = 6'h03;
  localparam logic [ADDR_W-1:0] ADDR_P4_LATCH = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_P0_DRV = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_P1_DIR = 6'h09;
  localparam logic [ADDR_W-1:0] ADDR_P4_DRV = 6'h0A;
  localparam logic [ADDR_W-1:0] ADDR_P0_PIN = 6'h0B;
  localparam logic [ADDR_W-1:0] ADDR_P2_PIN = 6'h0C;
  localparam logic [ADDR_W-1:0] ADDR_P3_PIN = 6'h0D;
  localparam logic [ADDR_W-1:0] ADDR_P4_PIN = 6'h0E;
  localparam logic [DATA_W-1:0] RST_ONES = 8'hFF;
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
  localparam logic [P2_W-1:0] RST_P2_ONES = 3'h7;
  localparam logic [DATA_W-1:0] P2_UNUSED_READ = 8'h00;
  localparam int P2_STOP_BIT = 0;
  localparam int P2_XIN_BIT = 1;
  localparam int P2_XOUT_BIT = 2;

  // pin drive of a port: output value and output enable
  typedef struct packed {
    logic [DATA_W-1:0] out;
    logic [DATA_W-1:0] oe;
  } port_drive_type;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_type;
endpackage : gpio_ports_pkg

// *** design/pin_driver.sv ***
// Purpose: per-bit pin driver with open-drain or push-pull selection
// Assumes: drv_sel 0 is sink open drain, 1 is push-pull
// Notes: open drain only pulls low, released while latch is one
`timescale 1ns/1ps
module pin_driver #(
  parameter int W = 8
) (
  input wire logic [W-1:0] i_latch,
  input wire logic [W-1:0] i_drv_sel,
  input wire logic [W-1:0] i_enable,
  output gpio_ports_pkg::port_drive_type o_drive
);
  import gpio_ports_pkg::*;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // push-pull drives both levels, open drain only sinks
      assign o_drive.out[g] = i_latch[g];
      assign o_drive.oe[g] = i_enable[g] & (i_drv_sel[g] | ~i_latch[g]);
    end
    for (g = W; g < DATA_W; g++) begin : g_pad
      assign o_drive.out[g] = 1'b0;
      assign o_drive.oe[g] = 1'b0;
    end
  endgenerate
endmodule : pin_driver

// *** test/pin_board.sv ***
// Purpose: board side of one port, pull-ups and external sources
// Assumes: a released pin floats high through its pull-up
// Notes: an external source drives a bit only while its enable is set
`timescale 1ns/1ps
module pin_board #(
  parameter int W = 8
) (
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_ext,
  input wire logic [W-1:0] i_ext_en,
  output logic [W-1:0] o_pin
);
  assign o_pin = (i_oe & i_out) | (~i_oe & (~i_ext_en | i_ext));
endmodule : pin_board

// *** test/mpio_asserts.sv ***
// Purpose: port-level checks of the parallel i/o block
// Assumes: read data stand only in the cycle after a read strobe
// Notes: bound to the top module
`timescale 1ns/1ps
module mpio_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [gpio_ports_pkg::ADDR_W-1:0] i_addr,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_global_output_enable,
  input wire logic i_dual_clock_mode,
  input wire logic i_stop_mode,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] o_port0_out,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] o_port0_oe,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] o_port1_out,
  input wire logic [gpio_ports_pkg::P2_W-1:0] o_port2_oe,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] o_port4_out,
  input wire logic [gpio_ports_pkg::DATA_W-1:0] o_port4_oe,
  input wire logic o_ext_int_edge,
  input wire logic o_crystal_select
);
  import gpio_ports_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence p1_all_out; i_wr && i_addr == ADDR_P1_DIR && i_wdata == 8'hFF; endsequence
  sequence p1_read; i_rd && i_addr == ADDR_P1_LATCH; endsequence
  sequence p3_write; i_wr && i_addr == ADDR_P3_LATCH; endsequence
  sequence p3_read; i_rd && i_addr == ADDR_P3_LATCH; endsequence
  a_read_idle:
    assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside read slot");
  a_latch_readback:
    assert property (p3_write ##2 p3_read |=> o_rdata == $past(i_wdata, 3)) else $error("latch readback");
  a_p1_out_read:
    assert property (p1_all_out ##2 p1_read |=> o_rdata == o_port1_out) else $error("output bit read");
  a_p2_upper_zero:
    assert property ($past(i_rd) && $past(i_addr) == ADDR_P2_LATCH |-> o_rdata[7:3] == 5'h00)
      else $error("port 2 upper bits");
  a_stop_float:
    assert property (i_stop_mode |-> !o_port2_oe[P2_STOP_BIT]) else $error("stop pin driven");
  a_crystal_float:
    assert property (i_dual_clock_mode |-> o_port2_oe[2:1] == 2'h0 && o_crystal_select)
      else $error("crystal pins driven");
  a_int_pulse:
    assert property ($rose(o_port2_oe[0]) |=> o_ext_int_edge ##1 !o_ext_int_edge) else $error("edge pulse");
  a_p0_sink_low:
    assert property (i_global_output_enable |-> (~o_port0_out & ~o_port0_oe) == 8'h00) else $error("p0 low");
  a_p4_sink_low:
    assert property (i_global_output_enable |-> (~o_port4_out & ~o_port4_oe) == 8'h00) else $error("p4 low");
endmodule : mpio_asserts
bind multi_port_parallel_io mpio_asserts mpio_asserts_inst (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_global_output_enable, .i_dual_clock_mode, .i_stop_mode, .o_port0_out, .o_port0_oe,
  .o_port1_out, .o_port2_oe, .o_port4_out, .o_port4_oe, .o_ext_int_edge, .o_crystal_select);

// *** test/test_multi_port_parallel_io.sv ***
// Purpose: register and pin tests of the parallel i/o block
// Assumes: board pulls released pins high
// Notes: pin reads wait for the two-flop input sync
`timescale 1ns/1ps
module test_multi_port_parallel_io;
  import gpio_ports_pkg::*;
  logic i_clk, i_rst_n, i_wr, i_rd, i_global_output_enable, i_dual_clock_mode, i_stop_mode;
  logic o_ext_int_edge, o_stop_release, o_crystal_select;
  logic [ADDR_W-1:0] i_addr;
  logic [7:0] i_wdata, o_rdata, i_port0_pin, i_port1_pin, i_port3_pin, i_port4_pin;
  logic [7:0] o_port0_out, o_port0_oe, o_port1_out, o_port1_oe, o_port3_out, o_port3_oe, o_port4_out, o_port4_oe;
  logic [P2_W-1:0] i_port2_pin, o_port2_out, o_port2_oe;
  logic [7:0] ext [5];
  logic [7:0] ext_en [5];
  int mismatches, total_checks;
  multi_port_parallel_io multi_port_parallel_io_inst (.*);
  pin_board pin_board_inst (.i_out(o_port0_out), .i_oe(o_port0_oe), .i_ext(ext[0]), .i_ext_en(ext_en[0]),
    .o_pin(i_port0_pin));
  pin_board pin_board_inst1 (.i_out(o_port1_out), .i_oe(o_port1_oe), .i_ext(ext[1]), .i_ext_en(ext_en[1]),
    .o_pin(i_port1_pin));
  pin_board #(.W(P2_W)) pin_board_inst2 (.i_out(o_port2_out), .i_oe(o_port2_oe), .i_ext(ext[2][2:0]),
    .i_ext_en(ext_en[2][2:0]), .o_pin(i_port2_pin));
  pin_board pin_board_inst3 (.i_out(o_port3_out), .i_oe(o_port3_oe), .i_ext(ext[3]), .i_ext_en(ext_en[3]),
    .o_pin(i_port3_pin));
  pin_board pin_board_inst4 (.i_out(o_port4_out), .i_oe(o_port4_oe), .i_ext(ext[4]), .i_ext_en(ext_en[4]),
    .o_pin(i_port4_pin));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask : rd
  task automatic final_report();
    $display("mismatches %0d total_checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata, i_dual_clock_mode, i_stop_mode} = '0;
    i_global_output_enable = 1'b1;
    ext = '{8'h5A, 8'h3C, 8'h05, 8'hC3, 8'h3C};
    ext_en = '{default: 8'h00};
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(ADDR_P0_LATCH, 8'hFF);
    rd(ADDR_P0_DRV, 8'h00);
    chk(o_port1_out, 8'h00);
    rd(ADDR_P1_DIR, 8'h00);
    rd(ADDR_P2_LATCH, 8'h07);
    rd(ADDR_P3_LATCH, 8'hFF);
    rd(ADDR_P4_LATCH, 8'hFF);
    rd(ADDR_P4_DRV, 8'h00);
    wr(6'h3F, 8'hA5);
    rd(6'h3F, 8'h00);
    @(posedge i_clk);
    ext_en <= '{default: 8'hFF};
    repeat (3) @(posedge i_clk);
    rd(ADDR_P0_PIN, 8'h5A);
    rd(ADDR_P2_PIN, 8'h05);
    rd(ADDR_P3_PIN, 8'hC3);
    rd(ADDR_P4_PIN, 8'h3C);
    wr(ADDR_P3_LATCH, 8'h96);
    chk(o_port3_out, 8'h96);
    chk(o_port3_oe, 8'h69);
    rd(ADDR_P3_LATCH, 8'h96);
    for (int p = 0; p < 2; p++) begin
      wr(p ? ADDR_P4_LATCH : ADDR_P0_LATCH, 8'h0F);
      chk(p ? o_port4_oe : o_port0_oe, 8'hF0);
      chk(p ? o_port4_out : o_port0_out, 8'h0F);
      wr(p ? ADDR_P4_DRV : ADDR_P0_DRV, 8'hFF);
      chk(p ? o_port4_oe : o_port0_oe, 8'hFF);
      wr(p ? ADDR_P4_LATCH : ADDR_P0_LATCH, 8'hFF);
      wr(p ? ADDR_P4_DRV : ADDR_P0_DRV, 8'h00);
      chk(p ? o_port4_oe : o_port0_oe, 8'h00);
    end
    wr(ADDR_P1_LATCH, 8'hA5);
    wr(ADDR_P1_DIR, 8'h0F);
    chk(o_port1_oe, 8'h0F);
    repeat (3) @(posedge i_clk);
    rd(ADDR_P1_LATCH, 8'h35);
    wr(ADDR_P1_LATCH, 8'h35);
    wr(ADDR_P1_DIR, 8'hFF);
    rd(ADDR_P1_LATCH, 8'h35);
    chk(o_port1_out, 8'h35);
    wr(ADDR_P2_LATCH, 8'h00);
    chk({5'h00, o_port2_oe}, 8'h07);
    chk({5'h00, o_port2_out}, 8'h00);
    @(posedge i_clk);
    #1;
    chk({7'h00, o_ext_int_edge}, 8'h01);
    @(posedge i_clk);
    i_stop_mode <= 1'b1;
    #1;
    chk({7'h00, o_ext_int_edge}, 8'h00);
    chk({5'h00, o_port2_oe}, 8'h06);
    repeat (3) @(posedge i_clk);
    #1;
    chk({7'h00, o_stop_release}, 8'h01);
    @(posedge i_clk);
    i_dual_clock_mode <= 1'b1;
    #1;
    chk({4'h0, o_crystal_select, o_port2_oe}, 8'h08);
    @(posedge i_clk);
    i_global_output_enable <= 1'b0;
    #1;
    chk(o_port1_oe, 8'h00);
    chk(o_port3_oe, 8'h00);
    final_report();
  end
  initial begin
    #50000;
    mismatches++;
    final_report();
  end
endmodule : test_multi_port_parallel_io
